// file: pkg/rpo_pkg.sv
package rpo_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] OFS_POH_STATUS0 = 16'h0287;
    localparam logic [15:0] OFS_IRQ_STAT_LABEL = 16'h028a;
    localparam logic [15:0] OFS_IRQ_STAT_PTR = 16'h028b;
    localparam logic [15:0] OFS_IRQ_EN_LABEL = 16'h028e;
    localparam logic [15:0] OFS_IRQ_EN_PTR = 16'h028f;
    localparam logic [15:0] OFS_RDI_ACCEPT = 16'h0293;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_RDI_VALUE = 3'h0;
    // label group bit positions
    localparam int BIT_PLM_CHG = 4;
    localparam int BIT_C2_NEW = 3;
    localparam int BIT_C2_UNST_CHG = 2;
    localparam int BIT_RDI_UNST_CHG = 1;
    localparam int BIT_RDI_NEW = 0;
    // pointer group bit positions
    localparam int BIT_B3_ERR = 7;
    localparam int BIT_PTR_NEW = 6;
    localparam int BIT_PTR_UNKNOWN = 5;
    localparam int BIT_PTR_DEC = 4;
    localparam int BIT_PTR_INC = 3;
    localparam int BIT_PTR_NDF = 2;
    localparam int BIT_LOP_CHG = 1;
    localparam int BIT_AIS_CHG = 0;
    // poh status byte 0 positions, then the low bit of the accepted remote defect value
    localparam int BIT_ST_C2_UNST = 6;
    localparam int BIT_ST_PLM = 4;
    localparam int BIT_ST_RDI_UNST = 2;
    localparam int BIT_ST_LOP = 1;
    localparam int BIT_ST_AIS = 0;
    localparam int BIT_RDI_ACC_LO = 4;
    // previous-level index of each watched defect
    localparam int DEF_PLM = 0;
    localparam int DEF_C2 = 1;
    localparam int DEF_RDI = 2;
    localparam int DEF_LOP = 3;
    localparam int DEF_AIS = 4;
    localparam int NUM_DEF = 5;
endpackage : rpo_pkg

// file: pkg/rpo_flag_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rpo_flag_if;
    logic [7:0] evt;
    logic [7:0] en;
    logic clr;
    logic [7:0] flags;
    modport bank (input evt, input en, input clr, output flags);
    modport owner (output evt, output en, output clr, input flags);
endinterface : rpo_flag_if
`default_nettype wire

// file: design/rpo_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_flag_bank
    import rpo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    rpo_flag_if.bank fl
);
    typedef struct packed {
        logic [7:0] flags;
    } rpo_bank_t;

    rpo_bank_t st_r;
    rpo_bank_t st_nxt;
    logic [7:0] bitNxt;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_flag
            // set beats the read clear so an event in the read cycle survives
            assign bitNxt[i] = (fl.evt[i] & fl.en[i]) | (st_r.flags[i] & ~fl.clr);
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.flags = bitNxt;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '{flags: RST_BYTE};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fl.flags = st_r.flags;
endmodule : rpo_flag_bank
`default_nettype wire

// file: design/rpo_irq_status.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - status flags read one after their event; a register read clears them
// - label bit 4 sets on payload mismatch declare and clear
// - label bit 3 sets on each accepted new C2 byte
// - label bit 2 sets on C2 unstable declare and clear
// - poh status byte 0 bit 6 shows C2 unstable state
// - label bit 1 sets on remote defect unstable declare and clear
// - poh status byte 0 bit 2 shows remote defect unstable state
// - label bit 0 sets on each validated new remote defect value
// - accepted remote defect value held in bits 6:4 of its register
// - pointer bit 7 sets on a B3 parity error
// - pointer bit 6 sets on a new pointer value
// - pointers carrying new data flag never set the new pointer bit
// - pointer bit 5 sets on any pointer fitting no known category
// - pointer bit 4 sets on a pointer decrement
// - pointer bit 3 sets on a pointer increment
// - pointer bit 2 sets on a new data flag pointer
// - pointer bit 1 sets on loss of pointer declare and clear
// - pointer bit 0 sets on path AIS declare and clear
module rpo_irq_status
    import rpo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic plmDefect,
    input wire logic c2UnstableDefect,
    input wire logic rdiUnstableDefect,
    input wire logic lopDefect,
    input wire logic aisDefect,
    input wire logic c2NewAccept,
    input wire logic rdiNewValid,
    input wire logic [2:0] rdiNewValue,
    input wire logic b3Error,
    input wire logic ptrSeen,
    input wire logic ptrNew,
    input wire logic ptrNdf,
    input wire logic ptrInc,
    input wire logic ptrDec,
    input wire logic ptrAllOnes,
    output logic irqReq
);
    typedef struct packed {
        logic [NUM_DEF-1:0] defPrev;
        logic [7:0] enLabel;
        logic [7:0] enPtr;
        logic [2:0] rdiAccept;
        logic [DATA_W-1:0] rdData;
        logic irq;
    } rpo_state_t;

    rpo_state_t st_r;
    rpo_state_t st_nxt;
    logic [NUM_DEF-1:0] defNow;
    logic [NUM_DEF-1:0] defChg;
    logic [7:0] evtLabel;
    logic [7:0] evtPtr;
    logic [7:0] pohStatus;
    logic unknownPtr;
    logic [7:0] labelNext;
    logic [7:0] ptrNext;

    rpo_flag_if labelIf ();
    rpo_flag_if ptrIf ();

    rpo_flag_bank u_label_bank (
        .mclk(mclk),
        .rst_n(rst_n),
        .fl(labelIf)
    );

    rpo_flag_bank u_ptr_bank (
        .mclk(mclk),
        .rst_n(rst_n),
        .fl(ptrIf)
    );

    always_comb begin
        defNow = '0;
        defNow[DEF_PLM] = plmDefect;
        defNow[DEF_C2] = c2UnstableDefect;
        defNow[DEF_RDI] = rdiUnstableDefect;
        defNow[DEF_LOP] = lopDefect;
        defNow[DEF_AIS] = aisDefect;
    end

    // both directions of each defect count as a change
    assign defChg = defNow ^ st_r.defPrev;

    // a pointer that no other category claims is flagged as unknown
    assign unknownPtr = ptrSeen & ~(ptrInc | ptrDec | ptrNdf | ptrAllOnes | ptrNew);

    always_comb begin
        evtLabel = '0;
        evtLabel[BIT_PLM_CHG] = defChg[DEF_PLM];
        evtLabel[BIT_C2_NEW] = c2NewAccept;
        evtLabel[BIT_C2_UNST_CHG] = defChg[DEF_C2];
        evtLabel[BIT_RDI_UNST_CHG] = defChg[DEF_RDI];
        evtLabel[BIT_RDI_NEW] = rdiNewValid;
    end

    always_comb begin
        evtPtr = '0;
        evtPtr[BIT_B3_ERR] = b3Error;
        evtPtr[BIT_PTR_NEW] = ptrNew & ~ptrNdf;
        evtPtr[BIT_PTR_UNKNOWN] = unknownPtr;
        evtPtr[BIT_PTR_DEC] = ptrDec;
        evtPtr[BIT_PTR_INC] = ptrInc;
        evtPtr[BIT_PTR_NDF] = ptrNdf;
        evtPtr[BIT_LOP_CHG] = defChg[DEF_LOP];
        evtPtr[BIT_AIS_CHG] = defChg[DEF_AIS];
    end

    always_comb begin
        pohStatus = '0;
        pohStatus[BIT_ST_C2_UNST] = c2UnstableDefect;
        pohStatus[BIT_ST_PLM] = plmDefect;
        pohStatus[BIT_ST_RDI_UNST] = rdiUnstableDefect;
        pohStatus[BIT_ST_LOP] = lopDefect;
        pohStatus[BIT_ST_AIS] = aisDefect;
    end

    assign labelIf.evt = evtLabel;
    assign labelIf.en = st_r.enLabel;
    assign labelIf.clr = regRd && (regAddr == OFS_IRQ_STAT_LABEL);
    assign ptrIf.evt = evtPtr;
    assign ptrIf.en = st_r.enPtr;
    assign ptrIf.clr = regRd && (regAddr == OFS_IRQ_STAT_PTR);

    // mirror of the banks' next flags so the request flop tracks them with no lag
    assign labelNext = (evtLabel & st_r.enLabel) | (labelIf.flags & ~{8{labelIf.clr}});
    assign ptrNext = (evtPtr & st_r.enPtr) | (ptrIf.flags & ~{8{ptrIf.clr}});

    always_comb begin
        st_nxt = st_r;
        st_nxt.defPrev = defNow;
        if (rdiNewValid) begin
            st_nxt.rdiAccept = rdiNewValue;
        end
        if (regWr) begin
            if (regAddr == OFS_IRQ_EN_LABEL) begin
                st_nxt.enLabel = regWrData;
            end else if (regAddr == OFS_IRQ_EN_PTR) begin
                st_nxt.enPtr = regWrData;
            end
        end
        st_nxt.rdData = RST_BYTE;
        if (regRd) begin
            // read data shows flags before the clear takes effect
            if (regAddr == OFS_IRQ_STAT_LABEL) begin
                st_nxt.rdData = labelIf.flags;
            end else if (regAddr == OFS_IRQ_STAT_PTR) begin
                st_nxt.rdData = ptrIf.flags;
            end else if (regAddr == OFS_IRQ_EN_LABEL) begin
                st_nxt.rdData = st_r.enLabel;
            end else if (regAddr == OFS_IRQ_EN_PTR) begin
                st_nxt.rdData = st_r.enPtr;
            end else if (regAddr == OFS_POH_STATUS0) begin
                st_nxt.rdData = pohStatus;
            end else if (regAddr == OFS_RDI_ACCEPT) begin
                st_nxt.rdData = {1'b0, st_r.rdiAccept, 4'h0};
            end else begin
                st_nxt.rdData = RST_BYTE;
            end
        end
        // flags only set while enabled, but an enable cleared later still masks them here
        st_nxt.irq = |((labelNext & st_nxt.enLabel) | (ptrNext & st_nxt.enPtr));
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r <= '{defPrev: '0, enLabel: RST_BYTE, enPtr: RST_BYTE,
                      rdiAccept: RST_RDI_VALUE, rdData: RST_BYTE, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign irqReq = st_r.irq;
endmodule : rpo_irq_status
`default_nettype wire

// file: test/rpo_irq_status_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_irq_status_asserts
    import rpo_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic plmDefect,
    input wire logic c2UnstableDefect,
    input wire logic rdiUnstableDefect,
    input wire logic rdiNewValid,
    input wire logic b3Error,
    input wire logic ptrNew,
    input wire logic ptrNdf,
    input wire logic ptrDec,
    input wire logic irqReq
);
    logic [7:0] enL_r;
    logic [7:0] enP_r;
    // enables are internal, so mirror them from the writes seen at the port
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enL_r <= 8'h00;
            enP_r <= 8'h00;
        end else if (regWr && regAddr == OFS_IRQ_EN_LABEL) begin
            enL_r <= regWrData;
        end else if (regWr && regAddr == OFS_IRQ_EN_PTR) begin
            enP_r <= regWrData;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data not zero outside read answer");
    a_b3_raises_irq: assert property (b3Error && enP_r[7] && !regWr |=> irqReq)
        else $error("b3 error did not raise irq");
    a_new_ptr_irq: assert property (ptrNew && !ptrNdf && enP_r[6] && !regWr |=> irqReq)
        else $error("new pointer did not raise irq");
    a_dec_ptr_irq: assert property (ptrDec && enP_r[4] && !regWr |=> irqReq)
        else $error("decrement did not raise irq");
    a_new_rdi_irq: assert property (rdiNewValid && enL_r[0] && !regWr |=> irqReq)
        else $error("new remote defect value did not raise irq");
    // past reset guard: reset level of the previous value is not the pin level
    a_plm_change_irq: assert property ($changed(plmDefect) && $past(rst_n) && enL_r[4]
        && !regWr |=> irqReq)
        else $error("payload mismatch change did not raise irq");
    a_status_live: assert property (regRd && regAddr == OFS_POH_STATUS0 |=>
        regRdData[6] == $past(c2UnstableDefect) && regRdData[2] == $past(rdiUnstableDefect))
        else $error("status byte does not show defect levels");
    a_masked_irq_low: assert property (enL_r == 8'h00 && enP_r == 8'h00 && !regWr |=> !irqReq)
        else $error("irq high with all enables off");
    c_b3_event: cover property (b3Error && enP_r[7]);
    c_flag_read: cover property (regRd && regAddr == OFS_IRQ_STAT_PTR && irqReq);
    c_plm_change: cover property ($changed(plmDefect) && enL_r[4]);
endmodule : rpo_irq_status_asserts
bind rpo_irq_status rpo_irq_status_asserts rpo_irq_status_asserts_i (.*);
`default_nettype wire

// file: test/rpo_irq_status_test.sv
`timescale 1ns/10ps
`default_nettype none
module rpo_irq_status_test
    import rpo_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    logic irqReq;
    logic [13:0] ev = 14'h0000;
    logic [2:0] rdiVal = 3'h0;
    logic [15:0] a;
    int n_errors = 0;
    int check_count = 0;
    logic [13:0] tv [14] = '{14'h0080, 14'h0200, 14'h0600, 14'h0100, 14'h2100, 14'h1000,
        14'h0800, 14'h0008, 14'h0010, 14'h0020, 14'h0040, 14'h0001, 14'h0002, 14'h0004};
    logic [7:0] te [14] = '{8'h80, 8'h40, 8'h04, 8'h20, 8'h00, 8'h10, 8'h08, 8'h02, 8'h01,
        8'h08, 8'h01, 8'h10, 8'h04, 8'h02};
    always #10 mclk = ~mclk;
    rpo_irq_status rpo_irq_status_i (.mclk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
        .regRdData, .plmDefect(ev[0]), .c2UnstableDefect(ev[1]), .rdiUnstableDefect(ev[2]),
        .lopDefect(ev[3]), .aisDefect(ev[4]), .c2NewAccept(ev[5]), .rdiNewValid(ev[6]),
        .rdiNewValue(rdiVal), .b3Error(ev[7]), .ptrSeen(ev[8]), .ptrNew(ev[9]), .ptrNdf(ev[10]),
        .ptrInc(ev[11]), .ptrDec(ev[12]), .ptrAllOnes(ev[13]), .irqReq);
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task wr(input logic [15:0] ad, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= ad;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [15:0] ad, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= ad;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk("read", regRdData, e);
    endtask : rd
    // pulses last one cycle, defect levels (low five bits) stay put
    task ev_set(input logic [13:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= v & 14'h001f;
    endtask : ev_set
    task stop_test;
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(OFS_IRQ_STAT_PTR, RST_BYTE);
        wr(OFS_IRQ_EN_PTR, 8'hff);
        wr(OFS_IRQ_EN_LABEL, 8'h1f);
        rd(OFS_IRQ_EN_LABEL, 8'h1f);
        rdiVal <= 3'h5;
        for (int i = 0; i < 14; i++) begin
            a = (i < 9) ? OFS_IRQ_STAT_PTR : OFS_IRQ_STAT_LABEL;
            ev_set(tv[i]);
            #1 chk("irq", {7'h00, irqReq}, {7'h00, te[i] != 8'h00});
            rd(a, te[i]);
            rd(a, 8'h00);
            chk("irq", {7'h00, irqReq}, 8'h00);
            ev_set(14'h0000);
            rd(a, (tv[i] & 14'h001f) != 14'h0000 ? te[i] : 8'h00);
        end
        rd(OFS_RDI_ACCEPT, 8'h50);
        ev_set(14'h001f);
        rd(OFS_POH_STATUS0, 8'h57);
        rd(OFS_IRQ_STAT_LABEL, 8'h16);
        rd(16'h0290, 8'h00);
        @(posedge mclk);
        regAddr <= OFS_IRQ_STAT_PTR;
        regRd <= 1'b1;
        ev <= 14'h009f;
        @(posedge mclk);
        regRd <= 1'b0;
        ev <= 14'h001f;
        #1 chk("race", regRdData, 8'h03);
        rd(OFS_IRQ_STAT_PTR, 8'h80);
        wr(OFS_IRQ_EN_PTR, 8'h00);
        ev_set(14'h0080);
        rd(OFS_IRQ_STAT_LABEL, 8'h16);
        rd(OFS_IRQ_STAT_PTR, 8'h00);
        chk("irq", {7'h00, irqReq}, 8'h00);
        stop_test;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        stop_test;
    end
endmodule : rpo_irq_status_test
`default_nettype wire
